// *** rtl/fcpd_core.sv ***
// Floppy command validation, parameter decode and sector sequencing
`timescale 1ns/100ps
`include "fcpd_params.svh"

module fcpd_core #(
  parameter int TICK_CYCLES = `FCPD_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  output logic cmd_ready_o,
  output logic irq_o,
  output logic result_valid_o,
  output logic [7:0] status0_o,
  output logic [7:0] present_cylinder_o,
  input wire logic step_tick_i,
  output logic step_o,
  output logic step_dir_o,
  input wire logic disk_byte_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] disk_wdata_o,
  output logic disk_write_o,
  output logic host_pass_o,
  output logic crc_en_o,
  output logic exec_busy_o,
  output logic [7:0] cylinder_o,
  output logic head_address_o,
  output logic [1:0] drive_o,
  output logic [7:0] sector_o,
  output logic [2:0] sector_size_code_o,
  output logic [7:0] gap3_length_o,
  output logic gap2_perp_o,
  output logic fifo_enable_n_o,
  output logic implied_seek_enable_o,
  output logic [1:0] perpendicular_drive_flags_o,
  output logic head_load_o,
  output logic head_ready_o
);

  // =============================================================
  // State
  fcpd_pkg::fcpd_state_type state_q;
  logic [7:0] p_q [0:7];
  logic [3:0] idx_q;
  logic [3:0] need_q;
  logic [7:0] op_q;
  logic invalid_q;
  logic [7:0] st0_q;
  logic [7:0] pcn_q;
  logic [7:0] steps_q;
  logic seek_rel_q;
  logic [7:0] end_of_track_sector_q;
  logic [7:0] special_sector_length_q;
  logic [7:0] sectors_per_track_q;
  logic [7:0] fill_q;
  logic [7:0] done_cnt_q;
  logic [14:0] byte_idx_q;
  logic sector_count_enable_q;
  logic gap2_select_q;
  logic [3:0] head_unload_interval_q;
  logic [6:0] head_load_interval_q;
  logic load_req_q;
  logic unload_req_q;

  // =============================================================
  // Opcode decode
  wire [4:0] in_op = cmd_byte_i[4:0];
  wire [4:0] cur_op = op_q[4:0];
  wire cmd_phase = (state_q == fcpd_pkg::ST_CMD) ||
                   (state_q == fcpd_pkg::ST_PARAM);
  wire take = cmd_valid_i && cmd_ready_o;
  wire in_rw = (in_op == `FCPD_OP_READ) || (in_op == `FCPD_OP_WRITE) ||
               (in_op == `FCPD_OP_VERIFY);
  wire in_known = in_rw || (in_op == `FCPD_OP_FORMAT) ||
                  (in_op == `FCPD_OP_RELSEEK) ||
                  (in_op == `FCPD_OP_PERP) ||
                  (in_op == `FCPD_OP_CONFIG) ||
                  (in_op == `FCPD_OP_SPECIFY) ||
                  (in_op == `FCPD_OP_SENSE);
  wire [3:0] in_need =
    in_rw ? `FCPD_NP_RW :
    (in_op == `FCPD_OP_FORMAT) ? `FCPD_NP_FORMAT :
    (in_op == `FCPD_OP_RELSEEK) ? `FCPD_NP_SEEK :
    (in_op == `FCPD_OP_PERP) ? `FCPD_NP_PERP :
    (in_op == `FCPD_OP_CONFIG) ? `FCPD_NP_CONFIG :
    (in_op == `FCPD_OP_SPECIFY) ? `FCPD_NP_SPECIFY : `FCPD_NP_NONE;
  wire take_op = take && (state_q == fcpd_pkg::ST_CMD);
  wire take_par = take && (state_q == fcpd_pkg::ST_PARAM);
  wire last_par = take_par && (idx_q == need_q - 4'h1);

  wire is_read = (cur_op == `FCPD_OP_READ);
  wire is_write = (cur_op == `FCPD_OP_WRITE);
  wire is_verify = (cur_op == `FCPD_OP_VERIFY);
  wire is_format = (cur_op == `FCPD_OP_FORMAT);
  wire is_rw = is_read || is_write || is_verify;

  // =============================================================
  // Parameter field views
  wire [7:0] p_cyl = p_q[1];
  wire p_head = p_q[0][`FCPD_HEAD_BIT];
  wire [1:0] p_drive = p_q[0][1:0];
  wire [2:0] p_n_rw = p_q[4][2:0];
  wire [2:0] p_n_fmt = p_q[1][2:0];
  wire [7:0] cfg = p_q[1];
  wire [7:0] perp = p_q[0];

  // Implied seek distance and direction toward the target cylinder
  wire seek_in = (p_cyl > pcn_q);
  wire [7:0] seek_dist = seek_in ? (p_cyl - pcn_q) : (pcn_q - p_cyl);
  wire need_seek = implied_seek_enable_o && (p_cyl != pcn_q);

  // =============================================================
  // Sector geometry
  wire [14:0] sector_bytes =
    `FCPD_SECTOR_BASE << sector_size_code_o;
  // Only size code 00 honours the special length; FF is expected else
  wire [14:0] xfer_len = (sector_size_code_o == 3'h0) ?
    {7'h00, special_sector_length_q} : sector_bytes;
  wire byte_pass = (byte_idx_q < xfer_len);
  wire sector_end = (byte_idx_q == sector_bytes - 15'h0001);
  wire [7:0] done_next = done_cnt_q + 8'h01;
  wire count_end = is_format || (is_verify && sector_count_enable_q);
  wire track_end = count_end ?
    (done_next == sectors_per_track_q) :
    (sector_o == end_of_track_sector_q);
  wire [7:0] write_byte = is_format ? fill_q :
    (byte_pass ? host_data_i : 8'h00);
  wire disk_evt = (state_q == fcpd_pkg::ST_XFER) && disk_byte_i;

  // =============================================================
  // Parameter capture, one register per entry
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_par
      always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
          p_q[gi] <= 8'h00;
        end else if (take_par && idx_q == 4'(gi)) begin
          p_q[gi] <= cmd_byte_i;
        end
      end
    end
  endgenerate

  // =============================================================
  // Byte-level outputs of the transfer
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      crc_en_o <= 1'b0;
      host_pass_o <= 1'b0;
      disk_write_o <= 1'b0;
      disk_wdata_o <= 8'h00;
    end else begin
      crc_en_o <= disk_evt;
      host_pass_o <= disk_evt && is_read && byte_pass;
      disk_write_o <= disk_evt && (is_write || is_format);
      if (disk_evt) begin
        disk_wdata_o <= write_byte;
      end
    end
  end

  // =============================================================
  // Mode outputs
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_ready_o <= 1'b0;
      gap2_perp_o <= 1'b0;
      exec_busy_o <= 1'b0;
    end else begin
      cmd_ready_o <= cmd_phase && !take;
      gap2_perp_o <= gap2_select_q && !drive_o[1] &&
                     perpendicular_drive_flags_o[drive_o[0]];
      exec_busy_o <= !cmd_phase;
    end
  end

  // =============================================================
  // Command sequencer
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= fcpd_pkg::ST_CMD;
      idx_q <= 4'h0;
      need_q <= 4'h0;
      op_q <= 8'h00;
      invalid_q <= 1'b0;
      irq_o <= 1'b0;
      st0_q <= `FCPD_ST0_NORMAL;
      status0_o <= `FCPD_ST0_NORMAL;
      result_valid_o <= 1'b0;
      pcn_q <= 8'h00;
      present_cylinder_o <= 8'h00;
      steps_q <= 8'h00;
      seek_rel_q <= 1'b0;
      step_o <= 1'b0;
      step_dir_o <= 1'b0;
      cylinder_o <= 8'h00;
      head_address_o <= 1'b0;
      drive_o <= 2'h0;
      sector_o <= 8'h00;
      sector_size_code_o <= 3'h0;
      end_of_track_sector_q <= 8'h00;
      gap3_length_o <= 8'h00;
      special_sector_length_q <= 8'h00;
      sectors_per_track_q <= 8'h00;
      fill_q <= 8'h00;
      done_cnt_q <= 8'h00;
      byte_idx_q <= 15'h0000;
      sector_count_enable_q <= 1'b0;
      fifo_enable_n_o <= `FCPD_FIFO_ENABLE_N_RESET;
      implied_seek_enable_o <= 1'b0;
      perpendicular_drive_flags_o <= 2'h0;
      gap2_select_q <= 1'b0;
      head_unload_interval_q <= 4'h0;
      head_load_interval_q <= 7'h00;
      load_req_q <= 1'b0;
      unload_req_q <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      step_o <= 1'b0;
      load_req_q <= 1'b0;
      unload_req_q <= 1'b0;
      unique case (state_q)
        fcpd_pkg::ST_CMD: begin
          if (take_op && !in_known) begin
            irq_o <= 1'b1;
            invalid_q <= 1'b1;
          end else if (take_op && in_op == `FCPD_OP_SENSE) begin
            status0_o <= invalid_q ? `FCPD_ST0_INVALID : st0_q;
            present_cylinder_o <= pcn_q;
            result_valid_o <= 1'b1;
            irq_o <= 1'b0;
            invalid_q <= 1'b0;
            st0_q <= `FCPD_ST0_NORMAL;
          end else if (take_op) begin
            op_q <= cmd_byte_i;
            need_q <= in_need;
            idx_q <= 4'h0;
            state_q <= fcpd_pkg::ST_PARAM;
          end
        end
        fcpd_pkg::ST_PARAM: begin
          if (last_par) begin
            state_q <= fcpd_pkg::ST_EXEC;
          end else if (take_par) begin
            idx_q <= idx_q + 4'h1;
          end
        end
        fcpd_pkg::ST_EXEC: begin
          state_q <= fcpd_pkg::ST_CMD;
          if (cur_op == `FCPD_OP_CONFIG) begin
            implied_seek_enable_o <= cfg[`FCPD_EIS_BIT];
            fifo_enable_n_o <= cfg[`FCPD_FIFO_ENABLE_N_BIT];
          end
          if (cur_op == `FCPD_OP_SPECIFY) begin
            head_unload_interval_q <= p_q[0][`FCPD_HUT_LSB +: 4];
            head_load_interval_q <= p_q[1][`FCPD_HLT_LSB +: 7];
          end
          if (cur_op == `FCPD_OP_PERP && perp[`FCPD_OW_BIT]) begin
            perpendicular_drive_flags_o <=
              perp[`FCPD_PERP_LSB +: 2];
          end
          if (cur_op == `FCPD_OP_PERP) begin
            gap2_select_q <= perp[`FCPD_GAP_BIT];
          end
          if (cur_op == `FCPD_OP_RELSEEK) begin
            drive_o <= p_drive;
            head_address_o <= p_head;
            step_dir_o <= op_q[`FCPD_DIR_BIT];
            steps_q <= p_q[1];
            seek_rel_q <= 1'b1;
            state_q <= fcpd_pkg::ST_SEEK;
          end
          if (is_rw) begin
            drive_o <= p_drive;
            head_address_o <= p_q[2][0];
            cylinder_o <= p_cyl;
            sector_o <= p_q[3];
            sector_size_code_o <= p_n_rw;
            end_of_track_sector_q <= p_q[5];
            gap3_length_o <= p_q[6];
            special_sector_length_q <= p_q[7];
            sectors_per_track_q <= p_q[7];
            sector_count_enable_q <= is_verify &&
                                     op_q[`FCPD_EC_BIT];
          end
          if (is_format) begin
            drive_o <= p_drive;
            head_address_o <= p_head;
            cylinder_o <= pcn_q;
            sector_o <= `FCPD_FMT_FIRST_SECTOR;
            sector_size_code_o <= p_n_fmt;
            sectors_per_track_q <= p_q[2];
            gap3_length_o <= p_q[3];
            fill_q <= p_q[4];
          end
          if (is_rw && need_seek) begin
            step_dir_o <= seek_in;
            steps_q <= seek_dist;
            seek_rel_q <= 1'b0;
            state_q <= fcpd_pkg::ST_SEEK;
          end else if (is_rw || is_format) begin
            load_req_q <= 1'b1;
            state_q <= fcpd_pkg::ST_LOAD;
          end
          done_cnt_q <= 8'h00;
          byte_idx_q <= 15'h0000;
        end
        fcpd_pkg::ST_SEEK: begin
          if (step_tick_i && steps_q == 8'h00) begin
            if (seek_rel_q) begin
              st0_q <= `FCPD_ST0_SEEK_END;
              state_q <= fcpd_pkg::ST_DONE;
            end else begin
              load_req_q <= 1'b1;
              state_q <= fcpd_pkg::ST_LOAD;
            end
          end else if (step_tick_i) begin
            step_o <= 1'b1;
            steps_q <= steps_q - 8'h01;
            // Inward is toward higher cylinder numbers
            pcn_q <= step_dir_o ? pcn_q + 8'h01 :
                                  pcn_q - 8'h01;
          end
        end
        fcpd_pkg::ST_LOAD: begin
          if (head_ready_o && !load_req_q) begin
            state_q <= fcpd_pkg::ST_XFER;
          end
        end
        fcpd_pkg::ST_XFER: begin
          if (disk_byte_i && sector_end) begin
            byte_idx_q <= 15'h0000;
            done_cnt_q <= done_next;
            sector_o <= sector_o + 8'h01;
            if (track_end) begin
              st0_q <= `FCPD_ST0_NORMAL;
              unload_req_q <= 1'b1;
              state_q <= fcpd_pkg::ST_DONE;
            end
          end else if (disk_byte_i) begin
            byte_idx_q <= byte_idx_q + 15'h0001;
          end
        end
        fcpd_pkg::ST_DONE: begin
          irq_o <= 1'b1;
          invalid_q <= 1'b0;
          state_q <= fcpd_pkg::ST_CMD;
        end
      endcase
    end
  end

  // =============================================================
  // Head load and unload timing
  fcpd_head_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_head_timer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .load_req_i(load_req_q),
    .unload_req_i(unload_req_q),
    .load_ticks_i(head_load_interval_q),
    .unload_ticks_i(head_unload_interval_q),
    .head_load_o(head_load_o),
    .head_ready_o(head_ready_o)
  );

endmodule

// *** rtl/fcpd_params.svh ***
// Constants of the floppy command and parameter decoder
`ifndef FCPD_PARAMS_SVH
`define FCPD_PARAMS_SVH

// =============================================================
// Opcodes, low five bits of the first command byte
`define FCPD_OP_READ 5'h06
`define FCPD_OP_WRITE 5'h05
`define FCPD_OP_VERIFY 5'h16
`define FCPD_OP_FORMAT 5'h0D
`define FCPD_OP_RELSEEK 5'h0F
`define FCPD_OP_PERP 5'h12
`define FCPD_OP_CONFIG 5'h13
`define FCPD_OP_SPECIFY 5'h03
`define FCPD_OP_SENSE 5'h08

// =============================================================
// Parameter byte counts per command
`define FCPD_NP_RW 4'h8
`define FCPD_NP_FORMAT 4'h5
`define FCPD_NP_SEEK 4'h2
`define FCPD_NP_PERP 4'h1
`define FCPD_NP_CONFIG 4'h3
`define FCPD_NP_SPECIFY 4'h2
`define FCPD_NP_NONE 4'h0

// =============================================================
// Field positions
`define FCPD_HEAD_BIT 2
`define FCPD_DIR_BIT 6
`define FCPD_EC_BIT 7
`define FCPD_EIS_BIT 6
`define FCPD_FIFO_ENABLE_N_BIT 5
`define FCPD_GAP_BIT 1
`define FCPD_PERP_LSB 2
`define FCPD_OW_BIT 7
`define FCPD_HUT_LSB 0
`define FCPD_HLT_LSB 1

// =============================================================
// Status codes and reset values
`define FCPD_ST0_NORMAL 8'h00
`define FCPD_ST0_SEEK_END 8'h20
`define FCPD_ST0_INVALID 8'h80
`define FCPD_FIFO_ENABLE_N_RESET 1'b1
`define FCPD_SECTOR_BASE 15'h0080
`define FCPD_FMT_FIRST_SECTOR 8'h01

// =============================================================
// Timing: head interval unit
`define FCPD_CLK_PERIOD_NS 25
`define FCPD_TICK_NS 1000000
`define FCPD_TICK_CYCLES \
  ((`FCPD_TICK_NS + `FCPD_CLK_PERIOD_NS - 1) / `FCPD_CLK_PERIOD_NS)

`endif

// *** rtl/fcpd_pkg.sv ***
// Types of the floppy command and parameter decoder
package fcpd_pkg;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_PARAM,
    ST_EXEC,
    ST_SEEK,
    ST_LOAD,
    ST_XFER,
    ST_DONE
  } fcpd_state_type;

  typedef enum logic [1:0] {
    HEAD_IDLE,
    HEAD_SETTLE,
    HEAD_READY,
    HEAD_HOLD
  } fcpd_head_type;

endpackage

// *** rtl/fcpd_head_timer.sv ***
// Head load settle and head unload delay timer
`timescale 1ns/100ps
`include "fcpd_params.svh"

module fcpd_head_timer #(
  parameter int TICK_CYCLES = `FCPD_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic load_req_i,
  input wire logic unload_req_i,
  input wire logic [6:0] load_ticks_i,
  input wire logic [3:0] unload_ticks_i,
  output logic head_load_o,
  output logic head_ready_o
);

  fcpd_pkg::fcpd_head_type state_q;
  logic [15:0] pre_q;
  logic [6:0] cnt_q;
  wire counting = (state_q == fcpd_pkg::HEAD_SETTLE) ||
                  (state_q == fcpd_pkg::HEAD_HOLD);
  wire tick = (pre_q == 16'(TICK_CYCLES - 1));

  // =============================================================
  // Interval prescaler, restarted for each interval
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pre_q <= 16'h0000;
    end else if (!counting || tick || load_req_i || unload_req_i) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // =============================================================
  // Head state
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= fcpd_pkg::HEAD_IDLE;
      cnt_q <= 7'h00;
      head_load_o <= 1'b0;
      head_ready_o <= 1'b0;
    end else begin
      unique case (state_q)
        fcpd_pkg::HEAD_IDLE: begin
          if (load_req_i) begin
            state_q <= fcpd_pkg::HEAD_SETTLE;
            cnt_q <= load_ticks_i;
            head_load_o <= 1'b1;
          end
        end
        fcpd_pkg::HEAD_SETTLE: begin
          if (tick && cnt_q == 7'h00) begin
            state_q <= fcpd_pkg::HEAD_READY;
            head_ready_o <= 1'b1;
          end else if (tick) begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        fcpd_pkg::HEAD_READY: begin
          if (unload_req_i) begin
            state_q <= fcpd_pkg::HEAD_HOLD;
            cnt_q <= {3'h0, unload_ticks_i};
            head_ready_o <= 1'b0;
          end
        end
        fcpd_pkg::HEAD_HOLD: begin
          // A new load while still held needs no settle time
          if (load_req_i) begin
            state_q <= fcpd_pkg::HEAD_READY;
            head_ready_o <= 1'b1;
          end else if (tick && cnt_q == 7'h00) begin
            state_q <= fcpd_pkg::HEAD_IDLE;
            head_load_o <= 1'b0;
          end else if (tick) begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
      endcase
    end
  end

endmodule

// *** bench/fcpd_core_properties.sv ***
// Port checker of the floppy command decoder
`timescale 1ns/100ps
module fcpd_core_checker (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic irq_o,
  input wire logic result_valid_o,
  input wire logic exec_busy_o,
  input wire logic fifo_enable_n_o,
  input wire logic crc_en_o,
  input wire logic host_pass_o,
  input wire logic disk_write_o,
  input wire logic head_load_o,
  input wire logic head_ready_o,
  input wire logic gap2_perp_o,
  input wire logic [1:0] drive_o,
  input wire logic [1:0] perpendicular_drive_flags_o,
  input wire logic step_o
);
  // =============================================================
  // Properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_take;
    cmd_valid_i && cmd_ready_o;
  endsequence
  sequence s_byte_moved;
    host_pass_o || disk_write_o;
  endsequence
  property p_ready_drop; s_take |=> !cmd_ready_o; endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready stayed high after a take");
  property p_ready_busy; cmd_ready_o |-> !exec_busy_o; endproperty
  a_ready_busy: assert property (p_ready_busy)
    else $error("ready offered outside command phase");
  property p_irq_cause;
    $rose(irq_o) |-> $past(cmd_valid_i && cmd_ready_o) || $past(exec_busy_o);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without a cause");
  property p_sense;
    result_valid_o |-> $past(cmd_valid_i && cmd_ready_o) && !irq_o;
  endproperty
  a_sense: assert property (p_sense)
    else $error("sense answer out of place");
  property p_fifo;
    $changed(fifo_enable_n_o) |-> $past(cmd_valid_i && cmd_ready_o, 2);
  endproperty
  a_fifo: assert property (p_fifo)
    else $error("fifo enable changed with no command");
  property p_crc; s_byte_moved |-> crc_en_o; endproperty
  a_crc: assert property (p_crc)
    else $error("moved byte left out of the check code");
  property p_head; crc_en_o |-> head_load_o && head_ready_o; endproperty
  a_head: assert property (p_head)
    else $error("byte moved before head settled");
  property p_gap;
    gap2_perp_o |->
      $past(!drive_o[1] && perpendicular_drive_flags_o[drive_o[0]]);
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap select active without perpendicular drive");
  property p_step; step_o |-> exec_busy_o && !cmd_ready_o; endproperty
  a_step: assert property (p_step)
    else $error("step outside execution");
endmodule

bind fcpd_core fcpd_core_checker u_checker (.clock_i(clock_i),
  .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .irq_o(irq_o), .result_valid_o(result_valid_o), .exec_busy_o(exec_busy_o),
  .fifo_enable_n_o(fifo_enable_n_o), .crc_en_o(crc_en_o),
  .host_pass_o(host_pass_o), .disk_write_o(disk_write_o),
  .head_load_o(head_load_o), .head_ready_o(head_ready_o),
  .gap2_perp_o(gap2_perp_o), .drive_o(drive_o),
  .perpendicular_drive_flags_o(perpendicular_drive_flags_o),
  .step_o(step_o));

// *** bench/fcpd_disk_model.sv ***
// Drive and data mover stand-in: step pacing, byte times, write data
`timescale 1ns/100ps
module fcpd_disk_model (
  input wire logic clock_i,
  input wire logic active_i,
  output logic step_tick_o,
  output logic disk_byte_o,
  output logic [7:0] host_data_o
);
  logic [1:0] phase_q;
  initial {step_tick_o, disk_byte_o, host_data_o, phase_q} = '0;
  // =============================================================
  // Paced on the falling edge; idle data is inverted so stale bytes show
  always @(negedge clock_i) begin
    phase_q <= active_i ? phase_q + 2'h1 : 2'h0;
    step_tick_o <= active_i && phase_q == 2'h3;
    disk_byte_o <= active_i && phase_q == 2'h1;
    host_data_o <= active_i ? 8'hA5 : 8'h5A;
  end
endmodule

// *** bench/fcpd_core_tb_top.sv ***
// Self-checking bench of the floppy command decoder
`timescale 1ns/100ps
module fcpd_core_tb_top;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_byte_i = 8'h00;
  logic cmd_ready_o, irq_o, result_valid_o, step_o, step_dir_o;
  logic disk_write_o, host_pass_o, crc_en_o, exec_busy_o, gap2_perp_o;
  logic head_address_o, fifo_enable_n_o, implied_seek_enable_o;
  logic head_load_o, head_ready_o, step_tick_i, disk_byte_i;
  logic [1:0] drive_o, perpendicular_drive_flags_o;
  logic [2:0] sector_size_code_o;
  logic [7:0] status0_o, present_cylinder_o, host_data_i, disk_wdata_o;
  logic [7:0] cylinder_o, sector_o, gap3_length_o, st, pcn, cyl;
  logic dir_seen;
  int miscompares = 0;
  int samples_checked = 0;
  int n_crc, n_pass, n_wr, n_fill, n_zero, n_step;
  always #12.5 clock_i = ~clock_i;
  fcpd_core #(.TICK_CYCLES(4)) u_dut (.clock_i(clock_i), .reset_i(reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
    .cmd_ready_o(cmd_ready_o), .irq_o(irq_o), .result_valid_o(result_valid_o),
    .status0_o(status0_o), .present_cylinder_o(present_cylinder_o),
    .step_tick_i(step_tick_i), .step_o(step_o), .step_dir_o(step_dir_o),
    .disk_byte_i(disk_byte_i), .host_data_i(host_data_i),
    .disk_wdata_o(disk_wdata_o), .disk_write_o(disk_write_o),
    .host_pass_o(host_pass_o), .crc_en_o(crc_en_o), .exec_busy_o(exec_busy_o),
    .cylinder_o(cylinder_o), .head_address_o(head_address_o),
    .drive_o(drive_o), .sector_o(sector_o),
    .sector_size_code_o(sector_size_code_o), .gap3_length_o(gap3_length_o),
    .gap2_perp_o(gap2_perp_o), .fifo_enable_n_o(fifo_enable_n_o),
    .implied_seek_enable_o(implied_seek_enable_o),
    .perpendicular_drive_flags_o(perpendicular_drive_flags_o),
    .head_load_o(head_load_o), .head_ready_o(head_ready_o));
  fcpd_disk_model u_disk (.clock_i(clock_i), .active_i(exec_busy_o),
    .step_tick_o(step_tick_i), .disk_byte_o(disk_byte_i),
    .host_data_o(host_data_i));
  // =============================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 200 && cmd_ready_o !== 1'b1; i++) @(negedge clock_i);
    if (i == 200) begin
      miscompares++;
      stop_test();
    end
  endtask
  // Byte is held from one falling edge across the taking rising edge
  task automatic send(input logic [7:0] b);
    wait_ready();
    cmd_valid_i = 1'b1;
    cmd_byte_i = b;
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic sense();
    int i;
    send(8'h08);
    for (i = 0; i < 20 && result_valid_o !== 1'b1; i++) @(negedge clock_i);
    st = status0_o;
    pcn = present_cylinder_o;
    check(result_valid_o, 1'b1);
    check(irq_o, 1'b0);
  endtask
  // Sends a command, then counts every byte pulse until the interrupt
  task automatic run(input logic [7:0] b[$], input logic [7:0] fill);
    int i;
    {n_crc, n_pass, n_wr, n_fill, n_zero, n_step} = '0;
    foreach (b[k]) send(b[k]);
    for (i = 0; i < 20000 && irq_o !== 1'b1; i++) begin
      @(negedge clock_i);
      n_crc += crc_en_o;
      n_pass += host_pass_o;
      n_wr += disk_write_o;
      n_fill += disk_write_o && disk_wdata_o === fill;
      n_zero += disk_write_o && disk_wdata_o === 8'h00;
      n_step += step_o;
      if (step_o) dir_seen = step_dir_o;
    end
    if (i == 20000) begin
      miscompares++;
      stop_test();
    end
  endtask
  // =============================================================
  // Scenarios
  task automatic t_invalid();
    run('{8'h1F}, 8'h00);
    check(n_crc + n_step, 0);
    sense();
    check(st, 8'h80);
    $display("invalid opcode test done");
  endtask
  task automatic cfg(input logic [7:0] p1);
    send(8'h13); send(8'h00); send(p1); send(8'h00);
    wait_ready();
    check(fifo_enable_n_o, p1[5]);
    check(implied_seek_enable_o, p1[6]);
    $display("configure test done");
  endtask
  task automatic perp(input logic [7:0] p0, input logic [1:0] flags);
    send(8'h12); send(p0);
    wait_ready();
    check(perpendicular_drive_flags_o, flags);
    $display("perpendicular test done");
  endtask
  task automatic t_read();
    run('{8'h06, 8'h04, 8'h05, 8'h01, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h10}, 0);
    check(n_crc, 128);
    check(n_pass, 16);
    check(n_step, 5);
    check(head_address_o, 1'b1);
    check(gap3_length_o, 8'h1B);
    check(sector_size_code_o, 3'h0);
    sense();
    check(pcn, 8'h05);
    for (int i = 0; i < 60 && head_load_o !== 1'b0; i++) @(negedge clock_i);
    check(head_load_o, 1'b0);
    $display("short read test done");
  endtask
  task automatic t_multi();
    // Nonzero size code, so the special length is sent as FF
    run('{8'h06, 8'h00, 8'h05, 8'h00, 8'h01, 8'h01, 8'h02, 8'h1B, 8'hFF}, 0);
    check(n_crc, 512);
    check(n_pass, 512);
    check(sector_o, 8'h03);
    check(gap2_perp_o, 1'b1);
    check(cylinder_o, 8'h05);
    sense();
    $display("multi sector test done");
  endtask
  task automatic t_write();
    run('{8'h05, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h08},
        8'hA5);
    check(n_wr, 128);
    check(n_fill, 8);
    check(n_zero, 120);
    check(n_crc, 128);
    sense();
    $display("short write test done");
  endtask
  task automatic t_format();
    run('{8'h0D, 8'h00, 8'h00, 8'h02, 8'h1B, 8'h5C}, 8'h5C);
    check(n_fill, 256);
    sense();
    $display("format test done");
  endtask
  task automatic t_verify();
    run('{8'h96, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, 8'h03}, 0);
    check(n_crc, 384);
    sense();
    $display("verify count test done");
  endtask
  task automatic seek(input logic dir, input logic [7:0] n);
    cyl = dir ? cyl + n : cyl - n;
    run('{{1'b0, dir, 6'h0F}, 8'h00, n}, 0);
    check(n_step, n);
    check(dir_seen, dir);
    sense();
    check(st, 8'h20);
    check(pcn, cyl);
    $display("relative seek test done");
  endtask
  initial begin
    repeat (4) @(negedge clock_i);
    check(fifo_enable_n_o, 1'b1);
    reset_i = 1'b0;
    send(8'h03); send(8'h01); send(8'h02);
    t_invalid();
    perp(8'h8E, 2'b11);
    perp(8'h06, 2'b11);
    perp(8'h86, 2'b01);
    cfg(8'h40);
    t_read();
    cfg(8'h20);
    t_multi();
    t_write();
    t_format();
    t_verify();
    cyl = 8'h05;
    seek(1'b1, 8'h03);
    seek(1'b0, 8'h02);
    seek(1'b1, 8'hF9);
    seek(1'b0, 8'hFF);
    stop_test();
  end
endmodule
